// [dv/eeprom_slave_model.sv]
module eeprom_slave_model (
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  input wire logic omit, // No word address byte
  output logic sda_oe // High pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [128];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic rd;
  logic sel;
  int bitn;
  int nbyte;

  initial
  begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) * 8'h25 + 8'h11;
    sda_oe = 1'b0;
    sel = 1'b0;
    rd = 1'b0;
    ptr = 8'h00;
    bitn = 99;
    nbyte = 0;
  end

  // ----------------------------------------
  // Framing
  // ----------------------------------------
  // Clock fall that ends a start is not a bit
  always @(negedge sda) if (scl === 1'b1)
  begin
    bitn = -1;
    nbyte = 0;
    sel = 1'b0;
    rd = 1'b0;
    sda_oe = 1'b0;
  end

  always @(posedge sda) if (scl === 1'b1)
  begin
    sel = 1'b0;
    bitn = 99;
    sda_oe = 1'b0;
  end

  // ----------------------------------------
  // Bits
  // ----------------------------------------
  always @(posedge scl)
  begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8 && rd && sel && nbyte > 0)
    begin
      ptr = ptr + 8'h01;
      if (sda) sel = 1'b0;
    end
  end

  always @(negedge scl) if (bitn < 99)
  begin
    bitn = bitn + 1;
    if (bitn == 8 && (nbyte == 0 || !rd))
    begin
      if (nbyte == 0)
      begin
        sel = sh[7:1] == 7'h50;
        rd = sh[0];
      end
      else if (sel && nbyte == 1 && !omit) ptr = sh;
      else if (sel)
      begin
        mem[ptr[6:0]] = sh;
        ptr = ptr + 8'h01;
      end
      sda_oe = sel;
    end
    else if (bitn == 8) sda_oe = 1'b0;
    else if (bitn == 9)
    begin
      bitn = 0;
      nbyte = nbyte + 1;
      sda_oe = rd && sel && !mem[ptr[6:0]][7];
    end
    else if (rd && sel && nbyte > 0 && bitn > 0) sda_oe = !mem[ptr[6:0]][7 - bitn];
  end
endmodule

// [dv/loader_monitor.sv]
module loader_monitor (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Reset, high
  input wire logic link_clk, // Bus timing clock
  input wire logic cmd_valid, // Request
  input wire logic cmd_ready, // Accept
  input wire logic rsp_valid, // Done pulse
  input wire logic rsp_nack, // Missing ack
  input wire logic ack_fail_flag, // Sticky failure
  input wire logic ack_fail_clear, // Failure clear
  input wire logic eeprom_present_flag, // Enabled
  input wire logic download_active, // Download running
  input wire logic cfg_wr_valid, // Config write pulse
  input wire eeprom_loader_pkg::cfg_wr_t cfg_wr, // Config write
  input wire logic scl_oe, // Clock pulled low
  input wire logic sda_oe // Data pulled low
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Command side
  // ----------------------------------------
  rsp_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid |=> !rsp_valid && cmd_ready) else $error("response pulse wrong");
  take_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_valid && cmd_ready |=> !cmd_ready [*3]) else $error("ready after take");
  ready_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_ready |-> eeprom_present_flag && !download_active) else $error("ready gated wrong");
  fail_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && rsp_nack |-> ##[0:4] ack_fail_flag) else $error("failure flag not set");
  fail_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    ack_fail_flag && !ack_fail_clear |=> ack_fail_flag) else $error("failure flag lost");
  bus_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_ready |-> !scl_oe && !sda_oe) else $error("bus driven while idle");

  // ----------------------------------------
  // Download side
  // ----------------------------------------
  cfg_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_valid |-> download_active ##1 !cfg_wr_valid) else $error("config pulse wrong");
  up_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_valid && cfg_wr.port == 2'h0 |-> cfg_wr.addr inside {[8'hb4:8'hea]})
    else $error("upstream address out of range");
  dn_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_valid && cfg_wr.port != 2'h0 |-> cfg_wr.addr inside {8'hc8, 8'hcc, 8'hcd,
    [8'hd0:8'hd5], 8'hec, 8'hee, 8'hef}) else $error("downstream address wrong");

  // ----------------------------------------
  // Wire
  // ----------------------------------------
  start_edge_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !scl_oe && !$past(scl_oe) && $rose(sda_oe) |-> ##[1:120] scl_oe)
    else $error("start not followed by clock low");
  stop_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !scl_oe && !$past(scl_oe) && $fell(sda_oe) |=> !scl_oe [*3])
    else $error("clock pulled after stop");

  cover property (@(posedge clk) cfg_wr_valid && cfg_wr.port == 2'h3);
  cover property (@(posedge clk) rsp_valid && rsp_nack);
  cover property (@(posedge clk) rsp_valid && !rsp_nack);
endmodule

// [dv/serial_eeprom_loader_master_test.sv]
module serial_eeprom_loader_master_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, sys_rst, link_clk, fundamental_reset_n, global_reset_n, omit;
  logic present_clear, ack_fail_clear, cmd_valid, cmd_rd, cmd_ready, rsp_valid;
  logic rsp_nack, ack_fail_flag, eeprom_present_flag, download_active, cfg_wr_valid;
  logic scl_out, scl_oe, sda_out, sda_oe, slv_oe, scl, sda;
  logic [6:0] cmd_dev;
  logic [7:0] cmd_waddr, cmd_wdata, rsp_data;
  eeprom_loader_pkg::cfg_wr_t cfg_wr;
  int n_fail, n_compared, cyc;
  localparam logic [7:0] up_addr [40] = '{8'h00, 8'h00, 8'hb4, 8'hb5, 8'hb8, 8'hb9, 8'hba,
    8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
    8'hc8, 8'hcc, 8'hcd, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hdc, 8'hde, 8'hdf, 8'h00, 8'h00,
    8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'he9, 8'hea};
  localparam logic [7:0] dn_addr [14] = '{8'h00, 8'h00, 8'hc8, 8'hcc, 8'hcd, 8'hd0, 8'hd1,
    8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hec, 8'hee, 8'hef};

  // Open-drain wires with pull-ups
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_oe ? sda_out : 1'b1) & !slv_oe;

  serial_eeprom_loader_master #(.QTR_CYC(2)) uut (.clk(clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .fundamental_reset_n(fundamental_reset_n),
    .global_reset_n(global_reset_n), .word_addr_omit_select(omit),
    .present_clear(present_clear), .ack_fail_clear(ack_fail_clear), .cmd_valid(cmd_valid),
    .cmd_rd(cmd_rd), .cmd_dev(cmd_dev), .cmd_waddr(cmd_waddr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .ack_fail_flag(ack_fail_flag), .eeprom_present_flag(eeprom_present_flag),
    .download_active(download_active), .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));

  eeprom_slave_model slave (.scl(scl), .sda(sda), .omit(omit), .sda_oe(slv_oe));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Phase offset keeps the two clocks unrelated
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i) * 8'h25 + 8'h11;
  endfunction

  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Download takes about 12k cycles at the short bit time
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  task automatic do_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] wa, wd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_rd <= rd;
    cmd_dev <= dev;
    cmd_waddr <= wa;
    cmd_wdata <= wd;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
  endtask

  task automatic s_download();
    eeprom_loader_pkg::cfg_wr_t q[$];
    logic [7:0] a;
    logic [1:0] p;
    int k;
    k = 0;
    do @(posedge clk); while (download_active !== 1'b1);
    do
    begin
      @(posedge clk);
      if (cfg_wr_valid === 1'b1) q.push_back(cfg_wr);
    end
    while (download_active !== 1'b0);
    for (int i = 0; i < 82; i++)
    begin
      a = i < 40 ? up_addr[i] : dn_addr[(i - 40) % 14];
      p = i < 40 ? 2'h0 : 2'((i - 40) / 14 + 1);
      if (a != 8'h00)
      begin
        check(k < q.size() ? q[k] : 18'h0, {p, a, pat(i)}, "map");
        k++;
      end
    end
    check(18'(q.size()), 18'h48, "config count");
    check(18'({ack_fail_flag, eeprom_present_flag}), 18'h1, "flags");
  endtask

  task automatic s_write_read();
    do_cmd(1'b0, 7'h50, 8'h10, 8'ha5);
    check(18'(rsp_nack), 18'h0, "write ack");
    check(18'(slave.mem[8'h10]), 18'ha5, "stored");
    do_cmd(1'b1, 7'h50, 8'h10, 8'h00);
    check(18'({rsp_nack, rsp_data}), 18'h0a5, "read back");
    do_cmd(1'b1, 7'h50, 8'h03, 8'h00);
    check(18'(rsp_data), 18'(pat(3)), "read byte");
  endtask

  task automatic s_omit();
    omit <= 1'b1;
    do_cmd(1'b0, 7'h50, 8'h77, 8'h3c);
    check(18'(slave.mem[8'h04]), 18'h3c, "omit write");
    do_cmd(1'b1, 7'h50, 8'h77, 8'h00);
    check(18'({rsp_nack, rsp_data}), 18'(pat(5)), "omit read");
    omit <= 1'b0;
  endtask

  task automatic s_nack();
    do_cmd(1'b0, 7'h51, 8'h20, 8'h5a);
    check(18'(rsp_nack), 18'h1, "address refused");
    repeat (4) @(posedge clk);
    check(18'(ack_fail_flag), 18'h1, "failure set");
    ack_fail_clear <= 1'b1;
    @(posedge clk);
    ack_fail_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check(18'(ack_fail_flag), 18'h0, "failure cleared");
  endtask

  task automatic s_present();
    present_clear <= 1'b1;
    @(posedge clk);
    present_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check(18'({eeprom_present_flag, cmd_ready, scl_out, sda_out}), 18'h0, "disabled");
  endtask

  initial
  begin
    {sys_rst, fundamental_reset_n, global_reset_n, omit} = 4'h8;
    {present_clear, ack_fail_clear, cmd_valid, cmd_rd} = 4'h0;
    cmd_dev = 7'h00;
    cmd_waddr = 8'h00;
    cmd_wdata = 8'h00;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    fundamental_reset_n <= 1'b1;
    global_reset_n <= 1'b1;
    s_download();
    s_write_read();
    s_omit();
    s_nack();
    s_present();
    finish_test();
  end
endmodule

bind serial_eeprom_loader_master loader_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .ack_fail_flag(ack_fail_flag),
  .ack_fail_clear(ack_fail_clear), .eeprom_present_flag(eeprom_present_flag),
  .download_active(download_active), .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
  .scl_oe(scl_oe), .sda_oe(sda_oe));

// [include/eeprom_loader_pkg.sv]
// What this block does
// [RQ1] Bus data moves as 8-bit bytes, each followed by one acknowledge bit.
// [RQ2] A byte receiver acknowledges by holding data low through the next clock high.
// [RQ3] Master runs single write, single read, and post-reset multiple-byte read.
// [RQ4] Write: start, address+0, word address, data MSB first, acks checked, stop.
// [RQ5] Missing address acknowledge sets the acknowledge-failure status flag.
// [RQ6] Read: start, address+0, word address, restart, address+1, byte, no-ack, stop.
// [RQ7] EEPROM acknowledges addresses and drives read bytes MSB first.
// [RQ8] Multi-byte read acks each byte while more wanted, then no-ack and stop.
// [RQ9] Word-address-omit select drops the word address byte and its ack.
// [RQ10] Download bytes 00h-27h load into upstream port configuration space.
// [RQ11] Download bytes 28h-35h load into downstream port 1 configuration space.
// [RQ12] Bytes 36h-43h load into port 2, bytes 44h-51h into port 3.
// [RQ13] Bytes 2 and 3 go to configuration addresses 0B4 and 0B5.
// [RQ14] Bytes 4 to 7 go in order to configuration addresses 0B8 to 0BB.
// [RQ15] Bytes 08h-0Fh go to 0BC-0C3, bytes 10h-13h to 0C4-0C7.
// [RQ16] Bytes 20h-23h go to configuration addresses 0E0 to 0E3.
// [RQ17] Byte 24h to 0E4, 25h/26h to 0E8/0E9, 27h to 0EA.
// [RQ18] Bytes 14h-1Dh go to reserved addresses 0C8-0DF per the loading map.
// [RQ19] Indicator bytes 0, 1E, 28 and unused byte 1F are not written.
// [RQ20] Post-reset download addresses the EEPROM at fixed address 1010_000X.
// [RQ21] Bus clock about 60 kHz while transferring, released while idle.
// [RQ22] Start/stop are data edges during clock high; otherwise data stable then.
// [RQ23] At later reset release, sample data pull-up to set the present flag.
// [RQ24] Download is one read from word 00h to 51h, only when present.
// [RQ25] Missing slave ack on a commanded operation stops the bus and flags failure.
package eeprom_loader_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int LINK_CLK_HZ = 12_500_000;
  localparam int SCL_HZ = 60_000;
  // Longest quarter bit time, rounded down
  localparam int QTR_CYC = LINK_CLK_HZ / (4 * SCL_HZ);

  // ----------------------------------------
  // Protocol constants
  // ----------------------------------------
  localparam logic [6:0] DL_DEV_ADDR = 7'h50;
  localparam logic [7:0] DL_FIRST = 8'h00;
  localparam logic [7:0] DL_LAST = 8'h51;
  localparam logic DIR_WR = 1'b0;
  localparam logic DIR_RD = 1'b1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] RX_IDLE = 8'hff;

  // ----------------------------------------
  // Download map
  // ----------------------------------------
  localparam logic [7:0] UP_LAST = 8'h27;
  localparam logic [7:0] DN1_BASE = 8'h28;
  localparam logic [7:0] DN2_BASE = 8'h36;
  localparam logic [7:0] DN3_BASE = 8'h44;
  localparam logic [1:0] PORT_UP = 2'h0;
  localparam logic [1:0] PORT_DN1 = 2'h1;
  localparam logic [1:0] PORT_DN2 = 2'h2;
  localparam logic [1:0] PORT_DN3 = 2'h3;
  localparam int MAP_VALID = 8;
  // Entry: valid bit over configuration address
  localparam logic [8:0] UP_MAP [40] = '{
    9'h000, 9'h000, 9'h1b4, 9'h1b5, 9'h1b8, 9'h1b9, 9'h1ba, 9'h1bb,
    9'h1bc, 9'h1bd, 9'h1be, 9'h1bf, 9'h1c0, 9'h1c1, 9'h1c2, 9'h1c3,
    9'h1c4, 9'h1c5, 9'h1c6, 9'h1c7, 9'h1c8, 9'h1cc, 9'h1cd, 9'h1d0,
    9'h1d1, 9'h1d2, 9'h1d3, 9'h1dc, 9'h1de, 9'h1df, 9'h000, 9'h000,
    9'h1e0, 9'h1e1, 9'h1e2, 9'h1e3, 9'h1e4, 9'h1e8, 9'h1e9, 9'h1ea};
  localparam logic [8:0] DN_MAP [14] = '{
    9'h000, 9'h000, 9'h1c8, 9'h1cc, 9'h1cd, 9'h1d0, 9'h1d1, 9'h1d2,
    9'h1d3, 9'h1d4, 9'h1d5, 9'h1ec, 9'h1ee, 9'h1ef};

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic dl;
    logic rd;
    logic omit;
    logic [6:0] dev;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } op_t;

  typedef struct packed {
    logic [1:0] port;
    logic [7:0] addr;
    logic [7:0] data;
  } cfg_wr_t;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_START = 4'b0010,
    L_BIT = 4'b0100,
    L_STOP = 4'b1000
  } link_state_t;

  typedef enum logic [4:0] {
    S_DEV_W = 5'b00001,
    S_WADDR = 5'b00010,
    S_DATA_W = 5'b00100,
    S_DEV_R = 5'b01000,
    S_DATA_R = 5'b10000
  } seg_t;

endpackage

// [src/serial_eeprom_loader_master.sv]
module serial_eeprom_loader_master #(
  parameter int QTR_CYC = eeprom_loader_pkg::QTR_CYC
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic link_clk, // Bus bit-timing clock
  input wire logic fundamental_reset_n, // Reset pin, low
  input wire logic global_reset_n, // Reset pin, low
  input wire logic word_addr_omit_select, // Drop word address phase
  input wire logic present_clear, // Clears present flag
  input wire logic ack_fail_clear, // Clears failure flag
  input wire logic cmd_valid, // Software command request
  input wire logic cmd_rd, // 1 read, 0 write
  input wire logic [6:0] cmd_dev, // Slave address
  input wire logic [7:0] cmd_waddr, // Word address
  input wire logic [7:0] cmd_wdata, // Write data
  output logic cmd_ready, // Command accepted when valid
  output logic rsp_valid, // Command finished pulse
  output logic [7:0] rsp_data, // Read data
  output logic rsp_nack, // Command hit a missing ack
  output logic ack_fail_flag, // Sticky failure status
  output logic eeprom_present_flag, // Interface enabled
  output logic download_active, // Post-reset download running
  output logic cfg_wr_valid, // Configuration byte write pulse
  output eeprom_loader_pkg::cfg_wr_t cfg_wr, // Port, address, data
  output logic scl_out, // Clock pin drive level
  output logic scl_oe, // Clock pin pulled low
  input wire logic sda_in, // Data pin level
  output logic sda_out, // Data pin drive level
  output logic sda_oe // Data pin pulled low
);

  // ----------------------------------------
  // System domain: pins and crossings in
  // ----------------------------------------
  logic fr_s1, fr_s2, gr_s1, gr_s2, sda_c1, sda_c2, resets_up;
  logic done_s1, done_s2, done_s3, byte_s1, byte_s2, byte_s3;
  logic busy, dl_pending, req_tgl;
  eeprom_loader_pkg::op_t op;

  always_ff @(posedge clk)
  begin
    fr_s1 <= fundamental_reset_n;
    fr_s2 <= fr_s1;
    gr_s1 <= global_reset_n;
    gr_s2 <= gr_s1;
    sda_c1 <= sda_in;
    sda_c2 <= sda_c1;
  end

  // Link results, held stable by the link until the next toggle
  logic done_tgl, byte_tgl, nack;
  logic [7:0] rx, rx_idx;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {done_s1, done_s2, done_s3} <= 3'h0;
      {byte_s1, byte_s2, byte_s3} <= 3'h0;
    end
    else
    begin
      {done_s1, done_s2, done_s3} <= {done_tgl, done_s1, done_s2};
      {byte_s1, byte_s2, byte_s3} <= {byte_tgl, byte_s1, byte_s2};
    end
  end

  // ----------------------------------------
  // System domain: control
  // ----------------------------------------
  wire both_high = fr_s2 & gr_s2;
  wire reset_rise = both_high & ~resets_up;
  wire done_evt = done_s2 ^ done_s3;
  wire byte_evt = byte_s2 ^ byte_s3;
  wire launch_dl = dl_pending & ~busy;
  wire launch_sw = cmd_valid & cmd_ready & ~launch_dl;
  wire launch = launch_dl | launch_sw;
  wire next_busy = launch | (busy & ~done_evt);
  // Later rising edge of the two resets samples the pull-up
  wire next_present = reset_rise ? sda_c2 : (eeprom_present_flag & ~present_clear); // RQ23
  wire next_pending = (reset_rise & sda_c2) | (dl_pending & ~launch_dl); // RQ24
  wire next_ack_fail = (done_evt & nack) | (ack_fail_flag & ~ack_fail_clear); // RQ5 RQ25

  eeprom_loader_pkg::op_t dl_op, sw_op, next_op;
  assign dl_op = '{dl: 1'b1, rd: 1'b1, omit: word_addr_omit_select,
                   dev: eeprom_loader_pkg::DL_DEV_ADDR, // RQ20
                   waddr: eeprom_loader_pkg::DL_FIRST, wdata: 8'h00}; // RQ24
  assign sw_op = '{dl: 1'b0, rd: cmd_rd, omit: word_addr_omit_select,
                   dev: cmd_dev, waddr: cmd_waddr, wdata: cmd_wdata}; // RQ3
  assign next_op = launch_dl ? dl_op : (launch_sw ? sw_op : op);

  // Download map lookup
  wire in_up = rx_idx <= eeprom_loader_pkg::UP_LAST; // RQ10
  wire in_dn3 = rx_idx >= eeprom_loader_pkg::DN3_BASE; // RQ12
  wire in_dn2 = (rx_idx >= eeprom_loader_pkg::DN2_BASE) & ~in_dn3; // RQ12
  wire [7:0] dn_base = in_dn3 ? eeprom_loader_pkg::DN3_BASE :
                       (in_dn2 ? eeprom_loader_pkg::DN2_BASE : eeprom_loader_pkg::DN1_BASE);
  wire [7:0] dn_off = rx_idx - dn_base; // RQ11
  // Table covers RQ13 to RQ19; invalid entries are never written
  wire [8:0] map_ent = in_up ? eeprom_loader_pkg::UP_MAP[rx_idx[5:0]] :
                       eeprom_loader_pkg::DN_MAP[dn_off[3:0]]; // RQ13 RQ14 RQ15 RQ16 RQ17 RQ18
  wire [1:0] map_port = in_up ? eeprom_loader_pkg::PORT_UP :
                        (in_dn3 ? eeprom_loader_pkg::PORT_DN3 :
                        (in_dn2 ? eeprom_loader_pkg::PORT_DN2 : eeprom_loader_pkg::PORT_DN1));
  wire map_hit = map_ent[eeprom_loader_pkg::MAP_VALID]; // RQ19

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      resets_up <= 1'b0;
      eeprom_present_flag <= 1'b0;
      dl_pending <= 1'b0;
      busy <= 1'b0;
      req_tgl <= 1'b0;
      op <= '0;
      cmd_ready <= 1'b0;
      download_active <= 1'b0;
      ack_fail_flag <= 1'b0;
    end
    else
    begin
      resets_up <= both_high;
      eeprom_present_flag <= next_present;
      dl_pending <= next_pending;
      busy <= next_busy;
      req_tgl <= req_tgl ^ launch;
      op <= next_op;
      cmd_ready <= ~next_busy & next_present & ~next_pending;
      download_active <= next_busy & next_op.dl;
      ack_fail_flag <= next_ack_fail;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
      cfg_wr_valid <= 1'b0;
      cfg_wr <= '0;
    end
    else
    begin
      rsp_valid <= done_evt & ~op.dl;
      rsp_data <= done_evt ? rx : rsp_data;
      rsp_nack <= done_evt ? nack : rsp_nack;
      cfg_wr_valid <= byte_evt & op.dl & map_hit;
      cfg_wr <= byte_evt ? {map_port, map_ent[7:0], rx} : cfg_wr;
    end
  end

  // ----------------------------------------
  // Link domain: reset and request crossing
  // ----------------------------------------
  logic lrst1, link_rst, req_l1, req_l2, req_l3, sda_l1, sda_l2;

  always_ff @(posedge link_clk)
  begin
    lrst1 <= sys_rst;
    link_rst <= lrst1;
    sda_l1 <= sda_in;
    sda_l2 <= sda_l1;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      {req_l1, req_l2, req_l3} <= 3'h0;
    else
      {req_l1, req_l2, req_l3} <= {req_tgl, req_l1, req_l2};
  end

  wire req_evt = req_l2 ^ req_l3;

  // ----------------------------------------
  // Link domain: bus engine
  // ----------------------------------------
  eeprom_loader_pkg::link_state_t state, next_state;
  eeprom_loader_pkg::seg_t seg, next_seg;
  eeprom_loader_pkg::op_t op_l;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, idx, next_idx, next_rx, next_rx_idx;
  logic next_scl_oe, next_sda_oe, next_nack, next_done, next_byte;

  // Quarter-bit ticks set the bus clock rate
  wire tick = (state != eeprom_loader_pkg::L_IDLE) && (qcnt == 16'(QTR_CYC - 1)); // RQ21
  wire is_ack = bitn == eeprom_loader_pkg::ACK_SLOT; // RQ1
  wire rd_seg = seg == eeprom_loader_pkg::S_DATA_R;
  wire more = op_l.dl & (idx != eeprom_loader_pkg::DL_LAST); // RQ8

  function automatic logic [7:0] seg_byte(input eeprom_loader_pkg::seg_t s,
                                          input eeprom_loader_pkg::op_t o);
    logic [7:0] b;
    b = eeprom_loader_pkg::RX_IDLE;
    unique case (s)
      eeprom_loader_pkg::S_DEV_W: b = {o.dev, eeprom_loader_pkg::DIR_WR};
      eeprom_loader_pkg::S_DEV_R: b = {o.dev, eeprom_loader_pkg::DIR_RD};
      eeprom_loader_pkg::S_WADDR: b = o.waddr;
      eeprom_loader_pkg::S_DATA_W: b = o.wdata;
      eeprom_loader_pkg::S_DATA_R: b = eeprom_loader_pkg::RX_IDLE;
    endcase
    return b;
  endfunction

  always_comb
  begin
    next_state = state;
    next_seg = seg;
    next_bitn = bitn;
    next_shreg = shreg;
    next_idx = idx;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_nack = nack;
    next_done = done_tgl;
    next_byte = byte_tgl;
    next_rx = rx;
    next_rx_idx = rx_idx;
    unique case (state)
      eeprom_loader_pkg::L_IDLE:
      begin
        next_scl_oe = 1'b0; // RQ21
        next_sda_oe = 1'b0;
        if (req_evt)
        begin
          next_state = eeprom_loader_pkg::L_START;
          next_nack = 1'b0;
          next_idx = eeprom_loader_pkg::DL_FIRST;
          // Omitted word address leaves no dummy write before a read
          next_seg = (op.rd & op.omit) ? eeprom_loader_pkg::S_DEV_R :
                     eeprom_loader_pkg::S_DEV_W; // RQ9
        end
      end
      eeprom_loader_pkg::L_START:
        if (tick)
          unique case (phase)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1; // RQ22
            2'h3:
            begin
              next_scl_oe = 1'b1;
              next_state = eeprom_loader_pkg::L_BIT;
              next_bitn = 4'h0;
              next_shreg = seg_byte(seg, op_l);
            end
          endcase
      eeprom_loader_pkg::L_BIT:
        if (tick)
          unique case (phase)
            // Data changes only while the clock is low
            2'h0: next_sda_oe = is_ack ? (rd_seg & more) : (~rd_seg & ~shreg[7]); // RQ4 RQ6 RQ8
            2'h1: next_scl_oe = 1'b0;
            2'h2:
              if (!is_ack)
                next_shreg = {shreg[6:0], sda_l2};
              else if (!rd_seg)
                next_nack = sda_l2; // RQ2 RQ5 RQ7
            2'h3:
            begin
              next_scl_oe = 1'b1;
              next_bitn = bitn + 4'h1;
              if (is_ack)
              begin
                next_bitn = 4'h0;
                next_state = eeprom_loader_pkg::L_BIT;
                if (nack)
                  next_state = eeprom_loader_pkg::L_STOP; // RQ25
                else
                  unique case (seg)
                    eeprom_loader_pkg::S_DEV_W:
                      next_seg = op_l.omit ? eeprom_loader_pkg::S_DATA_W :
                                 eeprom_loader_pkg::S_WADDR; // RQ9
                    eeprom_loader_pkg::S_WADDR:
                      if (op_l.rd)
                      begin
                        next_seg = eeprom_loader_pkg::S_DEV_R;
                        next_state = eeprom_loader_pkg::L_START; // RQ6
                      end
                      else
                        next_seg = eeprom_loader_pkg::S_DATA_W; // RQ4
                    eeprom_loader_pkg::S_DATA_W: next_state = eeprom_loader_pkg::L_STOP;
                    eeprom_loader_pkg::S_DEV_R: next_seg = eeprom_loader_pkg::S_DATA_R;
                    eeprom_loader_pkg::S_DATA_R:
                    begin
                      next_rx = shreg;
                      next_rx_idx = idx;
                      next_byte = ~byte_tgl;
                      next_idx = idx + 8'h01;
                      if (!more)
                        next_state = eeprom_loader_pkg::L_STOP; // RQ8
                    end
                  endcase
                next_shreg = seg_byte(next_seg, op_l);
              end
            end
          endcase
      eeprom_loader_pkg::L_STOP:
        if (tick)
          unique case (phase)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0; // RQ22
            2'h3:
            begin
              next_state = eeprom_loader_pkg::L_IDLE;
              next_done = ~done_tgl;
            end
          endcase
    endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state <= eeprom_loader_pkg::L_IDLE;
      seg <= eeprom_loader_pkg::S_DEV_W;
      op_l <= '0;
      qcnt <= 16'h0000;
      phase <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      idx <= 8'h00;
      nack <= 1'b0;
      done_tgl <= 1'b0;
      byte_tgl <= 1'b0;
      rx <= 8'h00;
      rx_idx <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      seg <= next_seg;
      op_l <= req_evt ? op : op_l;
      qcnt <= (state == eeprom_loader_pkg::L_IDLE || tick) ? 16'h0000 : qcnt + 16'h0001;
      phase <= (state == eeprom_loader_pkg::L_IDLE) ? 2'h0 : phase + {1'b0, tick};
      bitn <= next_bitn;
      shreg <= next_shreg;
      idx <= next_idx;
      nack <= next_nack;
      done_tgl <= next_done;
      byte_tgl <= next_byte;
      rx <= next_rx;
      rx_idx <= next_rx_idx;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge link_clk)
  begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

endmodule
